//--- core/srs_alu.sv
`timescale 1ns/100ps
module srs_alu (
   input wire logic [2:0] op,
   input wire logic [7:0] acc,
   input wire logic [7:0] opnd,
   input wire logic carry_in,
   output logic [7:0] result,
   output logic carry_out,
   output logic half_out,
   output logic zero_out
);
   function automatic logic [8:0] sub9(input logic [7:0] a, input logic [7:0] b);
      sub9 = {1'b0, a} + {1'b0, ~b} + 9'h001;
   endfunction
   logic [8:0] diff;
   logic [4:0] ndiff;
   always_comb begin
      diff = sub9(opnd, acc);
      ndiff = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
      result = diff[7:0];
      carry_out = diff[8];
      half_out = ndiff[4];
      zero_out = (diff[7:0] == 8'h00);
      if (op == 3'(srs_pkg::OP_RRC)) begin
         result = {carry_in, opnd[7:1]};
         carry_out = opnd[0];
      end
   end
endmodule

//--- core/srs_consts.svh
`ifndef SRS_CONSTS_SVH
`define SRS_CONSTS_SVH
`define SRS_ADDR_CMD 12'h000
`define SRS_ADDR_STATUS 12'h004
`define SRS_ADDR_ACC 12'h008
`define SRS_ADDR_FILE 12'h00c
`define SRS_ADDR_WDT 12'h010
`define SRS_CMD_OP_LSB 0
`define SRS_CMD_DEST_BIT 3
`define SRS_CMD_FADDR_LSB 8
`define SRS_CMD_LIT_LSB 16
`define SRS_ST_C 0
`define SRS_ST_DC 1
`define SRS_ST_Z 2
`define SRS_ST_PD 3
`define SRS_ST_TO 4
`define SRS_ST_SLEEP 5
`define SRS_STATUS_RST 8'h18
`define SRS_WDT_RST 8'h00
`define SRS_FILE_DEPTH 128
`endif

//--- core/srs_core.sv
`timescale 1ns/100ps
`include "srs_consts.svh"
module srs_core #(
   parameter int PRESCALE_W = 7
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic wake,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic osc_halt,
   output logic wdt_tick
);
   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] stat;
      logic [7:0] wdt;
      logic [PRESCALE_W-1:0] pre;
      logic sleep;
      logic [6:0] fsel;
      logic [31:0] rdata;
      logic [2:0] wsync;
      logic rd_done;
   } srs_state_t;
   srs_state_t state_reg, state_next;
   logic [7:0] file_mem [0:`SRS_FILE_DEPTH-1];
   logic [7:0] file_wdata;
   logic file_we;
   logic [6:0] file_waddr;
   logic wr_en, rd_en;
   logic [2:0] cmd_op;
   logic cmd_dest;
   logic [6:0] cmd_faddr;
   logic [7:0] cmd_lit, alu_opnd, alu_res;
   logic alu_c, alu_dc, alu_z;
   logic wake_ok;
   logic cmd_go;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   // Reads take one wait state so that read data stands from a flip-flop at the ready edge
   assign pready = !rd_en || state_reg.rd_done;
   // Wake pin counts once the second and third sync stages are both high
   assign wake_ok = state_reg.wsync[2] && state_reg.wsync[1];
   assign cmd_go = wr_en && paddr == `SRS_ADDR_CMD && !state_reg.sleep;
   assign cmd_op = pwdata[`SRS_CMD_OP_LSB +: 3];
   assign cmd_dest = pwdata[`SRS_CMD_DEST_BIT];
   assign cmd_faddr = pwdata[`SRS_CMD_FADDR_LSB +: 7];
   assign cmd_lit = pwdata[`SRS_CMD_LIT_LSB +: 8];
   assign alu_opnd = (cmd_op == 3'(srs_pkg::OP_LIT_SUB)) ? cmd_lit : file_mem[cmd_faddr];
   srs_alu u_alu (
      .op(cmd_op),
      .acc(state_reg.acc),
      .opnd(alu_opnd),
      .carry_in(state_reg.stat[`SRS_ST_C]),
      .result(alu_res),
      .carry_out(alu_c),
      .half_out(alu_dc),
      .zero_out(alu_z)
   );
   always_comb begin
      state_next = state_reg;
      file_we = 1'b0;
      file_waddr = 7'h00;
      file_wdata = alu_res;
      state_next.wsync = {state_reg.wsync[1:0], wake};
      state_next.rd_done = rd_en && !state_reg.rd_done;
      if (!state_reg.sleep) begin
         {state_next.wdt, state_next.pre} = {state_reg.wdt, state_reg.pre} + 1'b1;
      end
      if (state_reg.sleep && wake_ok) begin
         state_next.sleep = 1'b0;
      end
      if (rd_en && !state_reg.rd_done) begin
         case (paddr)
            `SRS_ADDR_STATUS: state_next.rdata = {24'h000000, state_reg.stat[7:6], state_reg.sleep,
                                                    state_reg.stat[4:0]};
            `SRS_ADDR_ACC: state_next.rdata = {24'h000000, state_reg.acc};
            `SRS_ADDR_FILE: state_next.rdata = {24'h000000, file_mem[state_reg.fsel]};
            `SRS_ADDR_WDT: state_next.rdata = {24'h000000, state_reg.wdt};
            default: state_next.rdata = 32'h00000000;
         endcase
      end
      if (wr_en && paddr == `SRS_ADDR_FILE) begin
         state_next.fsel = pwdata[14:8];
         file_we = pwdata[15];
         file_waddr = pwdata[14:8];
         file_wdata = pwdata[7:0];
      end
      if (wr_en && paddr == `SRS_ADDR_ACC) begin
         state_next.acc = pwdata[7:0];
      end
      if (wr_en && paddr == `SRS_ADDR_CMD && !state_reg.sleep) begin
         case (cmd_op)
            3'(srs_pkg::OP_SLEEP): begin
               state_next.wdt = `SRS_WDT_RST;
               state_next.pre = '0;
               state_next.stat[`SRS_ST_PD] = 1'b0;
               state_next.stat[`SRS_ST_TO] = 1'b1;
               state_next.sleep = 1'b1;
            end
            3'(srs_pkg::OP_RRC): begin
               state_next.stat[`SRS_ST_C] = alu_c;
               if (cmd_dest) begin
                  file_we = 1'b1;
                  file_waddr = cmd_faddr;
               end else begin
                  state_next.acc = alu_res;
               end
            end
            3'(srs_pkg::OP_LIT_SUB): begin
               state_next.acc = alu_res;
               state_next.stat[`SRS_ST_C] = alu_c;
               state_next.stat[`SRS_ST_DC] = alu_dc;
               state_next.stat[`SRS_ST_Z] = alu_z;
            end
            3'(srs_pkg::OP_FILE_SUB): begin
               state_next.stat[`SRS_ST_C] = alu_c;
               state_next.stat[`SRS_ST_DC] = alu_dc;
               state_next.stat[`SRS_ST_Z] = alu_z;
               if (cmd_dest) begin
                  file_we = 1'b1;
                  file_waddr = cmd_faddr;
               end else begin
                  state_next.acc = alu_res;
               end
            end
            default: begin
            end
         endcase
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= '0;
         state_reg.stat <= `SRS_STATUS_RST;
      end else begin
         state_reg <= state_next;
      end
      if (file_we) begin
         file_mem[file_waddr] <= file_wdata;
      end
   end
   assign prdata = state_reg.rdata;
   assign pslverr = 1'b0;
   assign osc_halt = state_reg.sleep;
   assign wdt_tick = (state_reg.pre == '1) && !state_reg.sleep;
   // Read handshake: first access cycle waits, second answers
   sequence s_read_first;
      rd_en && !state_reg.rd_done;
   endsequence
   sequence s_read_answer;
      !pready ##1 (pready && state_reg.rd_done);
   endsequence
   sequence s_wake_seen;
      state_reg.sleep && wake_ok;
   endsequence
   sequence s_sleep_cmd;
      cmd_go && cmd_op == 3'(srs_pkg::OP_SLEEP);
   endsequence
   chk_sleep_wdt_zero: assert property (@(posedge mclk) disable iff (rst)
      s_sleep_cmd
      |=> state_reg.wdt == 8'h00 && state_reg.pre == '0 && osc_halt)
      else $error("watchdog not cleared on sleep");
   chk_sleep_flags_set: assert property (@(posedge mclk) disable iff (rst)
      s_sleep_cmd
      |=> !state_reg.stat[`SRS_ST_PD] && state_reg.stat[`SRS_ST_TO]
          && state_reg.stat[2:0] == $past(state_reg.stat[2:0]))
      else $error("sleep flags wrong");
   chk_sleep_holds_wdt: assert property (@(posedge mclk) disable iff (rst)
      state_reg.sleep && !wake_ok
      |=> $stable(state_reg.wdt) && $stable(state_reg.pre) && state_reg.sleep)
      else $error("sleep state not held");
   chk_sleep_cmd_ignored: assert property (@(posedge mclk) disable iff (rst)
      wr_en && paddr == `SRS_ADDR_CMD && state_reg.sleep
      |=> $stable(state_reg.acc) && $stable(state_reg.stat))
      else $error("command taken while asleep");
   chk_wake_leaves: assert property (@(posedge mclk) disable iff (rst)
      s_wake_seen
      |=> !state_reg.sleep && !osc_halt)
      else $error("wake not taken");
   chk_tick_asleep: assert property (@(posedge mclk) disable iff (rst)
      state_reg.sleep
      |-> !wdt_tick)
      else $error("watchdog tick while asleep");
   chk_wake_sync: assert property (@(posedge mclk) disable iff (rst)
      state_reg.sleep && !state_reg.wsync[1]
      |=> state_reg.sleep)
      else $error("wake taken before sync");
   chk_wdt_counts: assert property (@(posedge mclk) disable iff (rst)
      !state_reg.sleep && !(cmd_go && cmd_op == 3'(srs_pkg::OP_SLEEP))
      |=> {state_reg.wdt, state_reg.pre} == (8 + PRESCALE_W)'($past({state_reg.wdt, state_reg.pre}) + 1'b1))
      else $error("watchdog not counting");
   chk_read_wait: assert property (@(posedge mclk) disable iff (rst)
      s_read_first
      |-> s_read_answer)
      else $error("read handshake wrong");
   chk_rrc_result_acc: assert property (@(posedge mclk) disable iff (rst)
      cmd_go && cmd_op == 3'(srs_pkg::OP_RRC) && !cmd_dest
      |=> state_reg.acc == {$past(state_reg.stat[0]), $past(alu_opnd[7:1])}
          && state_reg.stat[0] == $past(alu_opnd[0]))
      else $error("rotate result wrong");
   chk_rrc_flags_keep: assert property (@(posedge mclk) disable iff (rst)
      cmd_go && cmd_op == 3'(srs_pkg::OP_RRC)
      |=> $stable(state_reg.stat[7:1]))
      else $error("rotate changed other flags");
   chk_rrc_file_keep: assert property (@(posedge mclk) disable iff (rst)
      cmd_go && cmd_op == 3'(srs_pkg::OP_RRC) && cmd_dest
      |=> $stable(state_reg.acc) && $stable(state_reg.stat[2:1]))
      else $error("rotate destination wrong");
   chk_rrc_file_write: assert property (@(posedge mclk) disable iff (rst)
      cmd_go && cmd_op == 3'(srs_pkg::OP_RRC) && cmd_dest
      |=> file_mem[$past(cmd_faddr)] == {$past(state_reg.stat[0]), $past(alu_opnd[7:1])}
          && state_reg.stat[0] == $past(alu_opnd[0]))
      else $error("rotate file result wrong");
   chk_lit_sub_carry: assert property (@(posedge mclk) disable iff (rst)
      cmd_go && cmd_op == 3'(srs_pkg::OP_LIT_SUB)
      |=> state_reg.stat[0] == ($past(state_reg.acc) <= $past(cmd_lit))
          && state_reg.stat[1] == ($past(state_reg.acc[3:0]) <= $past(cmd_lit[3:0])))
      else $error("literal subtract carries wrong");
   chk_lit_sub_acc: assert property (@(posedge mclk) disable iff (rst)
      cmd_go && cmd_op == 3'(srs_pkg::OP_LIT_SUB)
      |=> state_reg.acc == 8'($past(cmd_lit) - $past(state_reg.acc)))
      else $error("literal subtract result wrong");
   chk_lit_sub_keep: assert property (@(posedge mclk) disable iff (rst)
      cmd_go && cmd_op == 3'(srs_pkg::OP_LIT_SUB)
      |=> $stable(state_reg.stat[7:3]))
      else $error("literal subtract changed other flags");
   chk_file_sub_carry: assert property (@(posedge mclk) disable iff (rst)
      cmd_go && cmd_op == 3'(srs_pkg::OP_FILE_SUB)
      |=> state_reg.stat[0] == ($past(state_reg.acc) <= $past(alu_opnd))
          && state_reg.stat[1] == ($past(state_reg.acc[3:0]) <= $past(alu_opnd[3:0])))
      else $error("file subtract carries wrong");
   chk_file_sub_dest: assert property (@(posedge mclk) disable iff (rst)
      cmd_go && cmd_op == 3'(srs_pkg::OP_FILE_SUB) && !cmd_dest
      |=> state_reg.acc == 8'($past(alu_opnd) - $past(state_reg.acc)))
      else $error("file subtract destination wrong");
   chk_file_sub_write: assert property (@(posedge mclk) disable iff (rst)
      cmd_go && cmd_op == 3'(srs_pkg::OP_FILE_SUB) && cmd_dest
      |=> file_mem[$past(cmd_faddr)] == 8'($past(alu_opnd) - $past(state_reg.acc))
          && $stable(state_reg.acc))
      else $error("file subtract write wrong");
   chk_sub_zero_flag: assert property (@(posedge mclk) disable iff (rst)
      cmd_go && cmd_op == 3'(srs_pkg::OP_LIT_SUB)
      |=> state_reg.stat[2] == ($past(cmd_lit) == $past(state_reg.acc)))
      else $error("zero flag wrong");
   chk_file_zero_flag: assert property (@(posedge mclk) disable iff (rst)
      cmd_go && cmd_op == 3'(srs_pkg::OP_FILE_SUB)
      |=> state_reg.stat[2] == ($past(alu_opnd) == $past(state_reg.acc)))
      else $error("file zero flag wrong");
   chk_acc_load: assert property (@(posedge mclk) disable iff (rst)
      wr_en && paddr == `SRS_ADDR_ACC
      |=> state_reg.acc == $past(pwdata[7:0]))
      else $error("accumulator load wrong");
   chk_file_load: assert property (@(posedge mclk) disable iff (rst)
      wr_en && paddr == `SRS_ADDR_FILE && pwdata[15]
      |=> file_mem[$past(pwdata[14:8])] == $past(pwdata[7:0]))
      else $error("file load wrong");
   chk_status_read: assert property (@(posedge mclk) disable iff (rst)
      s_read_first and paddr == `SRS_ADDR_STATUS
      |=> prdata[5] == $past(state_reg.sleep) && prdata[4:0] == $past(state_reg.stat[4:0]))
      else $error("status read wrong");
endmodule

//--- core/srs_pkg.sv
package srs_pkg;
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_SLEEP = 3'b001,
      OP_RRC = 3'b010,
      OP_LIT_SUB = 3'b011,
      OP_FILE_SUB = 3'b100
   } srs_op_t;
endpackage

//--- test/tb_srs_core.sv
`timescale 1ns/100ps
`include "srs_consts.svh"
module tb_srs_core;
   logic mclk, rst, wake, psel, penable, pwrite, pready, pslverr, osc_halt, wdt_tick;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int n_errors = 0;
   int cmp_count = 0;
   srs_core i_dut (.mclk(mclk), .rst(rst), .wake(wake), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .osc_halt(osc_halt), .wdt_tick(wdt_tick));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task close_out;
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Setup, access until pready, read data taken at that edge, then one idle edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) begin
         n_errors++;
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   function logic [31:0] cmd(srs_pkg::srs_op_t op, logic d, logic [6:0] f, logic [7:0] lit);
      return {8'h00, lit, 1'b0, f, 4'h0, d, op};
   endfunction
   task put_file(input logic [6:0] f, input logic [7:0] v);
      apb(1'b1, `SRS_ADDR_FILE, {16'h0, 1'b1, f, v});
   endtask
   task get_file(input logic [6:0] f);
      apb(1'b1, `SRS_ADDR_FILE, {16'h0, 1'b0, f, 8'h00});
      apb(1'b0, `SRS_ADDR_FILE, 32'h0);
   endtask
   // Carry set leaves Z=1 DC=1, carry clear leaves Z=0 DC=0
   task set_c(input logic c);
      apb(1'b1, `SRS_ADDR_ACC, {31'h0, ~c});
      apb(1'b1, `SRS_ADDR_CMD, cmd(srs_pkg::OP_LIT_SUB, 1'b0, 7'h00, 8'h00));
   endtask
   task t_sleep;
      set_c(1'b1);
      repeat (300) @(posedge mclk);
      apb(1'b1, `SRS_ADDR_CMD, cmd(srs_pkg::OP_SLEEP, 1'b0, 7'h00, 8'h00));
      apb(1'b0, `SRS_ADDR_WDT, 32'h0);
      chk("wdt_sleep", rd[7:0], `SRS_WDT_RST);
      apb(1'b0, `SRS_ADDR_STATUS, 32'h0);
      chk("status_sleep", rd[7:0], 8'h37);
      chk("osc_halt", {7'h0, osc_halt}, 8'h01);
      chk("tick_asleep", {7'h0, wdt_tick}, 8'h00);
      apb(1'b1, `SRS_ADDR_CMD, cmd(srs_pkg::OP_LIT_SUB, 1'b0, 7'h00, 8'h05));
      apb(1'b0, `SRS_ADDR_ACC, 32'h0);
      chk("acc_asleep", rd[7:0], 8'h00);
      wake <= 1'b1;
      repeat (4) @(posedge mclk);
      wake <= 1'b0;
      @(posedge mclk);
      chk("osc_awake", {7'h0, osc_halt}, 8'h00);
      apb(1'b0, `SRS_ADDR_WDT, 32'h0);
      chk("wdt_wake", rd[7:0], 8'h00);
   endtask
   task t_rotate;
      logic [7:0] v, exp;
      logic [6:0] f;
      for (int i = 0; i < 8; i++) begin
         f = i[1] ? 7'h7f : 7'h00;
         v = 8'hb4 | {7'h0, i[2]};
         exp = {i[0], v[7:1]};
         put_file(f, v);
         set_c(i[0]);
         apb(1'b1, `SRS_ADDR_ACC, 32'h3c);
         apb(1'b1, `SRS_ADDR_CMD, cmd(srs_pkg::OP_RRC, i[1], f, 8'h00));
         get_file(f);
         chk("rrc_file", rd[7:0], i[1] ? exp : v);
         apb(1'b0, `SRS_ADDR_ACC, 32'h0);
         chk("rrc_acc", rd[7:0], i[1] ? 8'h3c : exp);
         apb(1'b0, `SRS_ADDR_STATUS, 32'h0);
         chk("rrc_flags", {5'h0, rd[2:0]}, {5'h0, i[0], i[0], v[0]});
      end
   endtask
   task t_sub;
      logic [7:0] opx [5] = '{8'h05, 8'h10, 8'h00, 8'hff, 8'h3a};
      logic [7:0] opa [5] = '{8'h05, 8'h01, 8'h01, 8'h00, 8'h3b};
      logic [7:0] x, a, diff;
      logic [6:0] f;
      for (int k = 0; k < 15; k++) begin
         x = opx[k % 5];
         a = opa[k % 5];
         f = 7'h40 + 7'(k);
         diff = x - a;
         put_file(f, x);
         apb(1'b1, `SRS_ADDR_ACC, {24'h0, a});
         if (k < 5) begin
            apb(1'b1, `SRS_ADDR_CMD, cmd(srs_pkg::OP_LIT_SUB, 1'b0, 7'h00, x));
         end else begin
            apb(1'b1, `SRS_ADDR_CMD, cmd(srs_pkg::OP_FILE_SUB, k >= 10, f, 8'h00));
         end
         apb(1'b0, `SRS_ADDR_ACC, 32'h0);
         chk("sub_acc", rd[7:0], k >= 10 ? a : diff);
         get_file(f);
         chk("sub_file", rd[7:0], k >= 10 ? diff : x);
         apb(1'b0, `SRS_ADDR_STATUS, 32'h0);
         chk("sub_flags", {5'h0, rd[2:0]}, {5'h0, diff == 8'h00, a[3:0] <= x[3:0], a <= x});
      end
   endtask
   initial begin
      rst = 1'b1;
      wake = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      apb(1'b0, `SRS_ADDR_STATUS, 32'h0);
      chk("status_reset", rd[7:0], `SRS_STATUS_RST);
      t_sleep();
      t_rotate();
      t_sub();
      close_out();
   end
   initial begin
      #500000;
      n_errors++;
      close_out();
   end
endmodule
